// >>> common/qsf_pkg.sv
// Constants and types for the quad serial flash bus front end
// Contract
// R1 - Single-line mode: instruction, address, write data sampled from serial_in on rising clock.
// R2 - Read data shifted out on serial_out, changing on falling clock edges.
// R3 - SPI modes 0 and 3 supported; clock idles low or high at select edges.
// R4 - Dual read instructions use data_line_0 and data_line_1, two bits per clock.
// R5 - Quad read instructions use four data lines, including write-protect and pause pins.
// R6 - Quad instructions accepted only while quad_enable_bit is set; code also accepts them in four-wire mode with it clear.
// R7 - Enter-four-wire instruction switches to four_wire_command_mode when quad_enable_bit set.
// R8 - Instruction takes two clocks on four lines in four-wire mode, else eight.
// R9 - Four-wire and SPI modes exclusive; exit instruction returns to SPI mode.
// R10 - Power-up and software reset leave the device in SPI mode.
// R11 - Power-up address width follows powerup_addr_width_bit: 0 three bytes, 1 four.
// R12 - Three-byte mode prefixes extended address register; four-byte mode ignores it.
// R13 - Enter and exit four-byte instructions switch width; current_addr_width_bit tracks it.
// R14 - Pause only in single and dual modes with quad_enable_bit clear.
// R15 - Pause starts at pause pin fall if clock low, else after next clock fall.
// R16 - Pause ends at pause pin rise if clock low, else after next clock fall.
// R17 - While paused, float serial_out, ignore inputs, keep partial instruction state.
// R18 - Host keeps select low during pause; releasing it resets instruction state.
// R19 - Reset-enable then reset starts a 30 us restore with no commands accepted.
// R20 - Pause_or_restart_select picks pause input (0) or active-low restart input (1).
// R21 - Restart pin low about 1 us restores power-on state, aborts; blocks commands.
// R22 - quad_enable_bit set disables pause and restart; the pin is a data line.
// R23 - Select high: device deselected, all data outputs high impedance.
// R24 - After power-up a new instruction needs a select high-to-low transition first.
// R25 - Instruction starts at first clock after select falls; select rise ends transfer.
package qsf_pkg;

  localparam int          CLK_MHZ      = 125;
  localparam int          SOFT_RST_NS  = 30000;
  localparam logic [11:0] SOFT_RST_CYC = 12'(SOFT_RST_NS * CLK_MHZ / 1000);
  localparam int          HW_RST_NS    = 1000;
  localparam logic [7:0]  HW_RST_CYC   = 8'((HW_RST_NS * CLK_MHZ + 999) / 1000);

  localparam logic [7:0] CMD_READ        = 8'h03;
  localparam logic [7:0] CMD_FAST_READ   = 8'h0B;
  localparam logic [7:0] CMD_DUAL_OUT_RD = 8'h3B;
  localparam logic [7:0] CMD_DUAL_IO_RD  = 8'hBB;
  localparam logic [7:0] CMD_QUAD_OUT_RD = 8'h6B;
  localparam logic [7:0] CMD_QUAD_IO_RD  = 8'hEB;
  localparam logic [7:0] CMD_WORD_IO_RD  = 8'hE7;
  localparam logic [7:0] CMD_PROGRAM     = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG   = 8'h32;
  localparam logic [7:0] CMD_ENTER_QPI   = 8'h38;
  localparam logic [7:0] CMD_EXIT_QPI    = 8'hFF;
  localparam logic [7:0] CMD_ENTER_4B    = 8'hB7;
  localparam logic [7:0] CMD_EXIT_4B     = 8'hE9;
  localparam logic [7:0] CMD_RST_EN      = 8'h66;
  localparam logic [7:0] CMD_RST         = 8'h99;

  localparam logic [3:0] DUMMY_FAST    = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
  localparam logic [3:0] DUMMY_WORD_IO = 4'h4;

  localparam logic [5:0] BYTE_BITS  = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic       QPI_RST    = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DIN   = 3'b100,
    ST_DOUT  = 3'b101,
    ST_SKIP  = 3'b110,
    ST_RESET = 3'b111
  } qsf_state_e;

  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] dl;
  } qsf_pins_s;

  typedef struct packed {
    logic       has_addr;
    logic       rd;
    logic       quad;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    logic [3:0] dummy;
  } qsf_cmd_s;

  typedef struct packed {
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic        addr_valid;
    logic [31:0] addr;
    logic        wr_valid;
    logic [7:0]  wr_data;
    logic        rd_next;
  } qsf_out_s;

endpackage

// >>> design/qsf_front.sv
// Serial bus front end: instruction, address, data phases, pause and resets
`timescale 1ns/10ps
module qsf_front (
  input  wire logic             clk_in,                     // System clock
  input  wire logic             rst_n_in,                   // Async reset, low
  input  wire logic             cs_n_in,                    // Chip select pin
  input  wire logic             sclk_in,                    // Serial clock pin
  input  wire logic [3:0]       data_line_in,               // Data pins in
  input  wire logic             quad_enable_bit_in,         // Quad enable bit
  input  wire logic             powerup_addr_width_bit_in,  // Power-up width
  input  wire logic             pause_or_restart_select_in, // Pin function
  input  wire logic [7:0]       ext_addr_in,                // Extended address
  input  wire logic [7:0]       rd_data_in,                 // Next read byte
  output logic [3:0]            data_line_out,              // Data pins out
  output logic [3:0]            data_line_oe_out,           // Data pins enable
  output qsf_pkg::qsf_out_s     host_out,                   // Decoded traffic
  output logic                  four_wire_command_mode_out, // Four-wire mode
  output logic                  current_addr_width_bit_out, // 1 = four bytes
  output logic                  paused_out,                 // Pause active
  output logic                  busy_out,                   // Reset in progress
  output logic                  abort_out                   // Restart pulse
);

  qsf_pkg::qsf_pins_s  sy1_r, sy2_r, prev_r;
  qsf_pkg::qsf_state_e st_r, st_nxt;
  qsf_pkg::qsf_cmd_s   info_r, info_nxt, cinf;
  qsf_pkg::qsf_out_s   out_nxt;
  logic [31:0]         sh_r, sh_nxt;
  logic [5:0]          bcnt_r, bcnt_nxt, bc;
  logic [3:0]          dcnt_r, dcnt_nxt;
  logic [7:0]          osh_r, osh_nxt, ob;
  logic [2:0]          ocnt_r, ocnt_nxt;
  logic                qpi_r, qpi_nxt, ads_r, ads_nxt;
  logic                arm_r, arm_nxt, rarm_r, rarm_nxt, init_r;
  logic                paused_nxt, busy_nxt, abort_nxt, refuse;
  logic [11:0]         rcnt_r, rcnt_nxt;
  logic [7:0]          hcnt_r, hcnt_nxt, code;
  logic [3:0]          dlo_nxt, dloe_nxt;
  logic [2:0]          clanes;
  logic                rise, fall_raw, fall, pause_fn, hw_low;

  function automatic qsf_pkg::qsf_cmd_s decode(input logic [7:0] c, input logic four_wire_command_mode);
    qsf_pkg::qsf_cmd_s i;
    i = '0;
    i.alanes = 3'd1;
    i.dlanes = 3'd1;
    case (c)
      qsf_pkg::CMD_READ: begin
        i.has_addr = 1'b1;
        i.rd = 1'b1;
      end
      qsf_pkg::CMD_FAST_READ: begin
        i.has_addr = 1'b1;
        i.rd = 1'b1;
        i.dummy = qsf_pkg::DUMMY_FAST;
      end
      qsf_pkg::CMD_DUAL_OUT_RD, qsf_pkg::CMD_DUAL_IO_RD: begin
        i.has_addr = 1'b1;
        i.rd = 1'b1;
        i.dlanes = 3'd2;
        i.alanes = (c == qsf_pkg::CMD_DUAL_IO_RD) ? 3'd2 : 3'd1;
        i.dummy = (c == qsf_pkg::CMD_DUAL_IO_RD) ? qsf_pkg::DUMMY_DUAL_IO : qsf_pkg::DUMMY_FAST;
      end
      qsf_pkg::CMD_QUAD_OUT_RD: begin
        i.has_addr = 1'b1;
        i.rd = 1'b1;
        i.quad = 1'b1;
        i.dlanes = 3'd4;
        i.dummy = qsf_pkg::DUMMY_FAST;
      end
      qsf_pkg::CMD_QUAD_IO_RD, qsf_pkg::CMD_WORD_IO_RD: begin
        i.has_addr = 1'b1;
        i.rd = 1'b1;
        i.quad = 1'b1;
        i.alanes = 3'd4;
        i.dlanes = 3'd4;
        i.dummy = (c == qsf_pkg::CMD_QUAD_IO_RD) ? qsf_pkg::DUMMY_QUAD_IO : qsf_pkg::DUMMY_WORD_IO;
      end
      qsf_pkg::CMD_PROGRAM: begin
        i.has_addr = 1'b1;
      end
      qsf_pkg::CMD_QUAD_PROG: begin
        i.has_addr = 1'b1;
        i.quad = 1'b1;
        i.dlanes = 3'd4;
      end
      qsf_pkg::CMD_ENTER_QPI: begin
        i.quad = 1'b1;
      end
      default: begin
        i.has_addr = 1'b0;
      end
    endcase
    if (four_wire_command_mode) begin
      i.alanes = 3'd4;
      i.dlanes = 3'd4;
    end
    return i;
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [2:0] n,
                                           input logic [3:0] d);
    case (n)
      3'd2:    return {s[29:0], d[1:0]};
      3'd4:    return {s[27:0], d[3:0]};
      default: return {s[30:0], d[0]};
    endcase
  endfunction

  // Two-flop synchronisers on every pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sy1_r  <= '{cs_n: 1'b1, sclk: 1'b0, dl: 4'hF};
      sy2_r  <= '{cs_n: 1'b1, sclk: 1'b0, dl: 4'hF};
      prev_r <= '{cs_n: 1'b1, sclk: 1'b0, dl: 4'hF};
    end else begin
      sy1_r  <= '{cs_n: cs_n_in, sclk: sclk_in, dl: data_line_in};
      sy2_r  <= sy1_r;
      prev_r <= sy2_r;
    end
  end

  // R14 R22 pause and restart only with quad_enable_bit clear
  assign pause_fn = !pause_or_restart_select_in && !quad_enable_bit_in && !qpi_r && !sy2_r.cs_n;
  // R20 pin three as restart
  assign hw_low   = pause_or_restart_select_in && !quad_enable_bit_in && !sy2_r.dl[3];
  assign fall_raw = !sy2_r.sclk && prev_r.sclk;
  // R17 clock edges ignored while paused
  assign rise     = sy2_r.sclk && !prev_r.sclk && !paused_out;
  assign fall     = fall_raw && !paused_out;
  assign clanes   = qpi_r ? 3'd4 : 3'd1;

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bcnt_nxt = bcnt_r;
    dcnt_nxt = dcnt_r;
    info_nxt = info_r;
    osh_nxt = osh_r;
    ocnt_nxt = ocnt_r;
    qpi_nxt = qpi_r;
    ads_nxt = ads_r;
    arm_nxt = arm_r;
    rarm_nxt = rarm_r;
    rcnt_nxt = rcnt_r;
    hcnt_nxt = 8'h00;
    paused_nxt = paused_out;
    abort_nxt = 1'b0;
    dlo_nxt = data_line_out;
    dloe_nxt = data_line_oe_out;
    out_nxt = host_out;
    out_nxt.cmd_valid = 1'b0;
    out_nxt.addr_valid = 1'b0;
    out_nxt.wr_valid = 1'b0;
    out_nxt.rd_next = 1'b0;
    bc = 6'h00;
    ob = 8'h00;
    code = 8'h00;
    cinf = '0;
    refuse = 1'b0;
    // R11 power-up width caught after reset release
    if (!init_r) begin
      ads_nxt = powerup_addr_width_bit_in;
    end
    // R24 select must be seen high first
    if (sy2_r.cs_n) begin
      arm_nxt = 1'b1;
    end
    // R15 R16 pause edges follow clock level
    if (!pause_fn) begin
      paused_nxt = 1'b0;
    end else if (!sy2_r.sclk || fall_raw) begin
      paused_nxt = !sy2_r.dl[3];
    end
    case (st_r)
      qsf_pkg::ST_IDLE: begin
        // R3 R25 new instruction at select fall, any clock level
        if (!sy2_r.cs_n && prev_r.cs_n && arm_r) begin
          st_nxt = qsf_pkg::ST_CMD;
          bcnt_nxt = 6'h00;
          sh_nxt = 32'h0000_0000;
          ocnt_nxt = 3'd0;
        end
      end
      qsf_pkg::ST_CMD: begin
        if (rise) begin
          // R1 R8 instruction over one or four lines
          sh_nxt = shift_in(sh_r, clanes, sy2_r.dl);
          bc = bcnt_r + {3'b000, clanes};
          bcnt_nxt = bc;
          if (bc == qsf_pkg::BYTE_BITS) begin
            code = sh_nxt[7:0];
            cinf = decode(code, qpi_r);
            info_nxt = cinf;
            bcnt_nxt = 6'h00;
            sh_nxt = 32'h0000_0000;
            st_nxt = qsf_pkg::ST_SKIP;
            // R6 quad codes refused without quad_enable_bit outside four-wire mode
            refuse = cinf.quad && !quad_enable_bit_in && !qpi_r;
            rarm_nxt = (code == qsf_pkg::CMD_RST_EN);
            if (!refuse) begin
              out_nxt.cmd_valid = 1'b1;
              out_nxt.cmd_code = code;
              if (cinf.has_addr) begin
                st_nxt = qsf_pkg::ST_ADDR;
              end
              case (code)
                // R7 enter four-wire mode
                qsf_pkg::CMD_ENTER_QPI: qpi_nxt = 1'b1;
                // R9 exit back to SPI mode
                qsf_pkg::CMD_EXIT_QPI:  qpi_nxt = 1'b0;
                // R13 address width switch
                qsf_pkg::CMD_ENTER_4B:  ads_nxt = 1'b1;
                qsf_pkg::CMD_EXIT_4B:   ads_nxt = 1'b0;
                qsf_pkg::CMD_RST: begin
                  // R19 R10 software reset after reset-enable
                  if (rarm_r) begin
                    st_nxt = qsf_pkg::ST_RESET;
                    rcnt_nxt = qsf_pkg::SOFT_RST_CYC;
                    qpi_nxt = qsf_pkg::QPI_RST;
                    ads_nxt = powerup_addr_width_bit_in;
                  end
                end
                default: qpi_nxt = qpi_r;
              endcase
            end
          end
        end
      end
      qsf_pkg::ST_ADDR: begin
        if (rise) begin
          sh_nxt = shift_in(sh_r, info_r.alanes, sy2_r.dl);
          bc = bcnt_r + {3'b000, info_r.alanes};
          bcnt_nxt = bc;
          if (bc == (ads_r ? qsf_pkg::ADDR4_BITS : qsf_pkg::ADDR3_BITS)) begin
            out_nxt.addr_valid = 1'b1;
            // R12 extended register only in three-byte mode
            out_nxt.addr = ads_r ? sh_nxt : {ext_addr_in, sh_nxt[23:0]};
            bcnt_nxt = 6'h00;
            dcnt_nxt = 4'h0;
            if (info_r.dummy != 4'h0) begin
              st_nxt = qsf_pkg::ST_DUMMY;
            end else begin
              st_nxt = info_r.rd ? qsf_pkg::ST_DOUT : qsf_pkg::ST_DIN;
            end
          end
        end
      end
      qsf_pkg::ST_DUMMY: begin
        if (rise) begin
          dcnt_nxt = dcnt_r + 4'h1;
          if (dcnt_nxt == info_r.dummy) begin
            st_nxt = info_r.rd ? qsf_pkg::ST_DOUT : qsf_pkg::ST_DIN;
          end
        end
      end
      qsf_pkg::ST_DIN: begin
        if (rise) begin
          sh_nxt = shift_in(sh_r, info_r.dlanes, sy2_r.dl);
          bc = bcnt_r + {3'b000, info_r.dlanes};
          bcnt_nxt = bc;
          if (bc == qsf_pkg::BYTE_BITS) begin
            out_nxt.wr_valid = 1'b1;
            out_nxt.wr_data = sh_nxt[7:0];
            bcnt_nxt = 6'h00;
          end
        end
      end
      qsf_pkg::ST_DOUT: begin
        // R2 R4 R5 output changes on falling clock
        if (fall) begin
          ob = (ocnt_r == 3'd0) ? rd_data_in : osh_r;
          out_nxt.rd_next = (ocnt_r == 3'd0);
          case (info_r.dlanes)
            3'd2: begin
              dlo_nxt = {2'b00, ob[7:6]};
              dloe_nxt = 4'b0011;
            end
            3'd4: begin
              dlo_nxt = ob[7:4];
              dloe_nxt = 4'b1111;
            end
            default: begin
              dlo_nxt = {2'b00, ob[7], 1'b0};
              dloe_nxt = 4'b0010;
            end
          endcase
          osh_nxt = 8'(ob << info_r.dlanes);
          ocnt_nxt = ocnt_r + info_r.dlanes;
        end
      end
      qsf_pkg::ST_RESET: begin
        rcnt_nxt = rcnt_r - 12'h001;
        if (rcnt_r == 12'h001) begin
          st_nxt = qsf_pkg::ST_IDLE;
        end
      end
      default: st_nxt = st_r;
    endcase
    // R18 R25 select rise ends any transfer
    if (sy2_r.cs_n && st_r != qsf_pkg::ST_RESET) begin
      st_nxt = qsf_pkg::ST_IDLE;
    end
    // R21 restart pin overrides everything
    if (hw_low) begin
      st_nxt = qsf_pkg::ST_IDLE;
      arm_nxt = 1'b0;
      paused_nxt = 1'b0;
      out_nxt.cmd_valid = 1'b0;
      out_nxt.addr_valid = 1'b0;
      out_nxt.wr_valid = 1'b0;
      out_nxt.rd_next = 1'b0;
      hcnt_nxt = (hcnt_r == qsf_pkg::HW_RST_CYC) ? hcnt_r : hcnt_r + 8'h01;
      if (hcnt_r == qsf_pkg::HW_RST_CYC - 8'h01) begin
        qpi_nxt = qsf_pkg::QPI_RST;
        ads_nxt = powerup_addr_width_bit_in;
        rarm_nxt = 1'b0;
        abort_nxt = 1'b1;
      end
    end
    // R23 R17 float when deselected or paused
    if (sy2_r.cs_n || paused_out || paused_nxt || st_nxt != qsf_pkg::ST_DOUT) begin
      dloe_nxt = 4'h0;
    end
    busy_nxt = hw_low || st_nxt == qsf_pkg::ST_RESET;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= qsf_pkg::ST_IDLE;
      info_r <= '0;
      sh_r <= 32'h0000_0000;
      bcnt_r <= 6'h00;
      dcnt_r <= 4'h0;
      osh_r <= 8'h00;
      ocnt_r <= 3'd0;
      qpi_r <= qsf_pkg::QPI_RST;
      ads_r <= 1'b0;
      arm_r <= 1'b0;
      rarm_r <= 1'b0;
      init_r <= 1'b0;
      rcnt_r <= 12'h000;
      hcnt_r <= 8'h00;
      paused_out <= 1'b0;
      busy_out <= 1'b0;
      abort_out <= 1'b0;
      data_line_out <= 4'h0;
      data_line_oe_out <= 4'h0;
      host_out <= '0;
    end else begin
      st_r <= st_nxt;
      info_r <= info_nxt;
      sh_r <= sh_nxt;
      bcnt_r <= bcnt_nxt;
      dcnt_r <= dcnt_nxt;
      osh_r <= osh_nxt;
      ocnt_r <= ocnt_nxt;
      qpi_r <= qpi_nxt;
      ads_r <= ads_nxt;
      arm_r <= arm_nxt;
      rarm_r <= rarm_nxt;
      init_r <= 1'b1;
      rcnt_r <= rcnt_nxt;
      hcnt_r <= hcnt_nxt;
      paused_out <= paused_nxt;
      busy_out <= busy_nxt;
      abort_out <= abort_nxt;
      data_line_out <= dlo_nxt;
      data_line_oe_out <= dloe_nxt;
      host_out <= out_nxt;
    end
  end

  assign four_wire_command_mode_out = qpi_r;
  assign current_addr_width_bit_out = ads_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  cs_high_float_a: assert property (sy2_r.cs_n |=> data_line_oe_out == 4'h0) // R23
    else $error("data lines driven while deselected");
  pause_float_a: assert property (paused_out |=> data_line_oe_out == 4'h0) // R17
    else $error("data lines driven while paused");
  pause_start_a: assert property (pause_fn && !sy2_r.dl[3] && !sy2_r.sclk |=> paused_out) // R15
    else $error("pause did not start with clock low");
  quad_refuse_a: assert property (host_out.cmd_valid && // R6
    (host_out.cmd_code == qsf_pkg::CMD_QUAD_IO_RD ||
    host_out.cmd_code == qsf_pkg::CMD_QUAD_OUT_RD)
    |-> $past(quad_enable_bit_in) || $past(qpi_r))
    else $error("quad instruction accepted without quad enable");
  qpi_enter_a: assert property ($rose(qpi_r) // R7
    |-> host_out.cmd_valid && host_out.cmd_code == qsf_pkg::CMD_ENTER_QPI)
    else $error("four-wire mode entered without its instruction");
  qpi_exit_a: assert property ($fell(qpi_r) |-> busy_out || (host_out.cmd_valid && // R9
    (host_out.cmd_code == qsf_pkg::CMD_EXIT_QPI || host_out.cmd_code == qsf_pkg::CMD_RST)))
    else $error("four-wire mode left without cause");
  ads_track_a: assert property ($changed(ads_r) && $past(init_r) |-> busy_out || // R13
    (host_out.cmd_valid && (host_out.cmd_code == qsf_pkg::CMD_ENTER_4B ||
    host_out.cmd_code == qsf_pkg::CMD_EXIT_4B || host_out.cmd_code == qsf_pkg::CMD_RST)))
    else $error("address width changed without cause");
  addr_ext_a: assert property (host_out.addr_valid && !ads_r // R12
    |-> host_out.addr[31:24] == $past(ext_addr_in))
    else $error("three-byte address lacks extended byte");
  soft_rst_hold_a: assert property (st_r == qsf_pkg::ST_RESET && rcnt_r > 12'h001 && !hw_low
    |=> st_r == qsf_pkg::ST_RESET && busy_out) // R19
    else $error("software reset period cut short");
  hw_block_a: assert property (hw_low |=> !host_out.cmd_valid && busy_out) // R21
    else $error("command accepted during restart");

endmodule

// >>> verif/qsf_host_model.sv
// Host controller model driving the serial flash pins
`timescale 1ns/10ps
module qsf_host_model (
  input  wire logic [3:0] pin_in,   // Resolved pin levels
  output logic            cs_n_out, // Chip select
  output logic            sclk_out, // Serial clock
  output logic [3:0]      dl_out,   // Pin drive values
  output logic [3:0]      oe_out    // Pin drive enables
);
  localparam realtime HALF = 62.5;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    dl_out   = 4'hC;
    oe_out   = 4'hC;
  end
  task automatic start();
    cs_n_out = 1'b0;
    #(HALF);
  endtask
  task automatic stop();
    #(HALF);
    cs_n_out = 1'b1;
    #(4*HALF);
  endtask
  // select stays low while pins toggle
  task automatic ticks(input int n);
    repeat (n) begin
      #(HALF) sclk_out = 1'b1;
      #(HALF) sclk_out = 1'b0;
    end
  endtask
  task automatic pin3(input logic v);
    dl_out[3] = v;
  endtask
  // bits set while clock low, MSB first
  task automatic send(input logic [31:0] v, input int n, input int lanes);
    for (int i = n - lanes; i >= 0; i -= lanes) begin
      oe_out = (lanes == 4) ? 4'hF : 4'hD;
      dl_out = (lanes == 4) ? v[i +: 4] : {3'b110, v[i]};
      ticks(1);
    end
    oe_out = 4'hC;
    dl_out = 4'hC;
  endtask
  task automatic recv(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      #(HALF) sclk_out = 1'b1;
      b = {b[6:0], pin_in[1]};
      #(HALF) sclk_out = 1'b0;
    end
  endtask
endmodule

// >>> verif/quad_serial_flash_bus_front_end_test.sv
// Self-checking bench for the serial flash bus front end
`timescale 1ns/10ps
module quad_serial_flash_bus_front_end_test;
  logic              clk_in, rst_n_in, qe, sel, pwr, cs_n, sclk;
  logic              tg = 1'b0;
  logic              fw, aw, paused, busy, abort;
  logic [7:0]        ext, rd, b;
  logic [31:0]       a;
  logic [3:0]        h_dl, h_oe, d_dl, d_oe, pins;
  qsf_pkg::qsf_out_s host_out;
  int                n_mismatch = 0, total_checks = 0, n_abort = 0;
  logic [7:0]        cmd_q[$];
  logic [31:0]       adr_q[$];
  logic [7:0]        wr_q[$];

  assign pins = (d_oe & d_dl) | (~d_oe & h_oe & h_dl) | (~d_oe & ~h_oe & {4{tg}});
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) tg <= ~tg;

  qsf_front qsf_front_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .data_line_in(pins), .quad_enable_bit_in(qe),
    .powerup_addr_width_bit_in(pwr), .pause_or_restart_select_in(sel),
    .ext_addr_in(ext), .rd_data_in(rd), .data_line_out(d_dl), .data_line_oe_out(d_oe),
    .host_out(host_out), .four_wire_command_mode_out(fw),
    .current_addr_width_bit_out(aw), .paused_out(paused), .busy_out(busy),
    .abort_out(abort));
  qsf_host_model qsf_host_model_inst (.pin_in(pins), .cs_n_out(cs_n), .sclk_out(sclk),
    .dl_out(h_dl), .oe_out(h_oe));

  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic op(input logic [7:0] c, input int lanes, input bit ok);
    if (ok) cmd_q.push_back(c);
    qsf_host_model_inst.start();
    qsf_host_model_inst.send({24'h0, c}, 8, lanes);
    qsf_host_model_inst.stop();
    clks(10);
  endtask
  task automatic rd_tail(input int nb);
    adr_q.push_back(nb == 32 ? a : {ext, a[23:0]});
    qsf_host_model_inst.send(a, nb, 1);
    qsf_host_model_inst.recv(b);
    qsf_host_model_inst.stop();
    chk(b === rd, "read data");
  endtask

  always @(negedge clk_in) begin
    if (host_out.cmd_valid === 1'b1) begin
      if (cmd_q.size() == 0) chk(1'b0, "unexpected instruction");
      else chk(host_out.cmd_code === cmd_q.pop_front(), "instruction code");
    end
    if (host_out.addr_valid === 1'b1) begin
      if (adr_q.size() == 0) chk(1'b0, "unexpected address");
      else chk(host_out.addr === adr_q.pop_front(), "address");
    end
    if (host_out.wr_valid === 1'b1) begin
      if (wr_q.size() == 0) chk(1'b0, "unexpected write data");
      else chk(host_out.wr_data === wr_q.pop_front(), "write data");
    end
    if (abort === 1'b1) n_abort++;
  end

  initial begin
    #700us;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst_n_in = 1'b0;
    {qe, sel} = 2'h0;
    ext = 8'h00;
    rd = 8'h00;
    void'($urandom(49));
    pwr = 1'($urandom);
    clks(16);
    rst_n_in = 1'b1;
    clks(4);
    chk(fw === 1'b0 && aw === pwr, "power-up mode");
    ext = 8'($urandom);
    rd = 8'($urandom);
    a = $urandom;
    cmd_q.push_back(qsf_pkg::CMD_READ);
    qsf_host_model_inst.start();
    qsf_host_model_inst.send(32'h0, 4, 1);
    qsf_host_model_inst.pin3(1'b0);
    clks(12);
    chk(paused === 1'b1 && d_oe === 4'h0, "pause entry");
    qsf_host_model_inst.ticks(3);
    qsf_host_model_inst.pin3(1'b1);
    clks(12);
    chk(paused === 1'b0, "pause exit");
    qsf_host_model_inst.send(32'h3, 4, 1);
    rd_tail(pwr ? 32 : 24);
    op(qsf_pkg::CMD_QUAD_OUT_RD, 1, 1'b0);
    op(qsf_pkg::CMD_ENTER_QPI, 1, 1'b0);
    op(qsf_pkg::CMD_ENTER_4B, 1, 1'b1);
    chk(fw === 1'b0 && aw === 1'b1, "four-byte entry");
    rd = 8'($urandom);
    a = $urandom;
    cmd_q.push_back(qsf_pkg::CMD_READ);
    qsf_host_model_inst.start();
    qsf_host_model_inst.send({24'h0, qsf_pkg::CMD_READ}, 8, 1);
    rd_tail(32);
    op(qsf_pkg::CMD_EXIT_4B, 1, 1'b1);
    chk(aw === 1'b0, "four-byte exit");
    wr_q.push_back(rd);
    cmd_q.push_back(qsf_pkg::CMD_PROGRAM);
    adr_q.push_back({ext, a[23:0]});
    qsf_host_model_inst.start();
    qsf_host_model_inst.send({24'h0, qsf_pkg::CMD_PROGRAM}, 8, 1);
    qsf_host_model_inst.send(a, 24, 1);
    qsf_host_model_inst.send({24'h0, rd}, 8, 1);
    qsf_host_model_inst.stop();
    clks(10);
    qe = 1'b1;
    op(qsf_pkg::CMD_QUAD_OUT_RD, 1, 1'b1);
    op(qsf_pkg::CMD_ENTER_QPI, 1, 1'b1);
    chk(fw === 1'b1, "four-wire entry");
    op(qsf_pkg::CMD_EXIT_QPI, 4, 1'b1);
    chk(fw === 1'b0, "four-wire exit");
    op(qsf_pkg::CMD_ENTER_QPI, 1, 1'b1);
    pwr = 1'b1;
    op(qsf_pkg::CMD_RST_EN, 4, 1'b1);
    op(qsf_pkg::CMD_RST, 4, 1'b1);
    chk(busy === 1'b1, "soft reset busy");
    op(qsf_pkg::CMD_RST_EN, 1, 1'b0);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) clks(1);
    chk(busy === 1'b0 && fw === 1'b0 && aw === 1'b1, "soft reset state");
    qe = 1'b0;
    sel = 1'b1;
    pwr = 1'b0;
    qsf_host_model_inst.pin3(1'b0);
    clks(140);
    chk(busy === 1'b1 && n_abort == 1, "restart");
    qsf_host_model_inst.pin3(1'b1);
    clks(10);
    chk(busy === 1'b0 && aw === 1'b0 && fw === 1'b0, "restart state");
    qe = 1'b1;
    sel = 1'($urandom);
    qsf_host_model_inst.pin3(1'b0);
    clks(140);
    chk(busy === 1'b0 && n_abort == 1 && paused === 1'b0, "restart disabled");
    qsf_host_model_inst.pin3(1'b1);
    clks(10);
    chk(d_oe === 4'h0 && cmd_q.size() == 0 && adr_q.size() == 0 && wr_q.size() == 0,
        "idle");
    wrap_up();
  end
endmodule
